// [include/scs_regs.svh]
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH
// Register offsets, fields, reset values and timing
`define SCS_PRESENCE_CFG_OFS 8'hf0
`define SCS_ABSENT_BIT 0
`define SCS_PRESENCE_CFG_RST 8'h00
`define SCS_REF_HZ 14318180
`define SCS_SLOW_HZ 32768
`define SCS_DIV_HALF ((`SCS_REF_HZ / `SCS_SLOW_HZ) / 2)
`endif

// [include/scs_pkg.sv]
`default_nettype none
package scs_pkg;
  // Host register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scs_host_req_type;
  // Wake-domain pins kept alive under trickle supply
  typedef struct packed {
    logic keyboard_data_line;
    logic mouse_data_line;
    logic infrared_receive_input;
    logic ring_indicate_first_n;
    logic ring_indicate_second_n;
    logic second_port_receive;
  } scs_wake_pins_type;
  // Clock mux select state
  typedef enum logic [1:0] {SCS_RUN, SCS_GATE_OFF, SCS_SWAP} scs_mux_state_type;
endpackage
`default_nettype wire

// [core/scs_slow_clock.sv]
`include "scs_regs.svh"
`default_nettype none
// Operation
// R1: Host cycles ignored while supply good low
// R2: Wake pins keep working without supply good
// R3: Supply good low disables infrared timeout
// R4: Trickle reset clears infrared and wake logic
// R5: Absent flag is bit0 of 0xf0
// R6: Flag 0 external clock, 1 absent
// R7: Flag selects external pin or internal divider
// R8: Internal source needs main supply only
// R9: Software sets flag when no oscillator
// R10: Source switch is glitch free
module scs_slow_clock #(
  parameter int DIV_HALF = `SCS_DIV_HALF
) (
  // Clock, trickle reset and enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Supply status pin
  input wire logic supply_good_indicator_i,
  // Host register port
  input wire scs_pkg::scs_host_req_type host_req_i,
  output logic [7:0] host_rdata_o,
  output logic host_ack_o,
  // Slow clock input pin and internal reference tick
  input wire logic slow_clock_input_pin_i,
  input wire logic ref_tick_i,
  // Wake pins in and out
  input wire scs_pkg::scs_wake_pins_type wake_pins_i,
  output scs_pkg::scs_wake_pins_type wake_pins_o,
  // Selected slow clock and status
  output logic slow_clock_o,
  output logic slow_clock_absent_flag_o,
  output logic ir_timeout_enable_o,
  output logic internal_source_valid_o
);
  import scs_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] pg_sync_reg; // Supply good pipeline
  logic [1:0] ext_sync_reg; // External slow clock pipeline
  scs_wake_pins_type wake_s1_reg; // First stage, wake pins
  scs_wake_pins_type wake_s2_reg; // Second stage, wake pins
  logic pg_ok;
  logic ext_clk;

  // Two flops on each pin input
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pg_sync_reg <= 2'h0;
      ext_sync_reg <= 2'h0;
      wake_s1_reg <= '0;
      wake_s2_reg <= '0;
    end else if (clk_en_i) begin
      pg_sync_reg <= {pg_sync_reg[0], supply_good_indicator_i};
      ext_sync_reg <= {ext_sync_reg[0], slow_clock_input_pin_i};
      wake_s1_reg <= wake_pins_i;
      wake_s2_reg <= wake_s1_reg;
    end
  end
  assign pg_ok = pg_sync_reg[1];
  assign ext_clk = ext_sync_reg[1];

  // Wake pins pass regardless of supply good
  assign wake_pins_o = wake_s2_reg; // R2
  // Half duplex timeout only while supply is good
  assign ir_timeout_enable_o = pg_ok; // R3

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  logic [7:0] presence_cfg_reg; // Trickle-domain config byte
  logic hit;
  logic [7:0] rdata_reg; // Read data
  logic ack_reg; // Access acknowledge

  // Address decode used by read and write
  function automatic logic cfg_hit(input logic [7:0] a);
    return a == `SCS_PRESENCE_CFG_OFS;
  endfunction
  assign hit = cfg_hit(host_req_i.addr);

  // Writes decoded only with supply good; cleared by trickle reset only
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presence_cfg_reg <= `SCS_PRESENCE_CFG_RST; // R4 R5 R6
    end else if (clk_en_i && pg_ok && host_req_i.wr && hit) begin // R1
      presence_cfg_reg <= host_req_i.wdata; // R9
    end
  end

  // Read path and acknowledge, silent while supply is low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else if (clk_en_i) begin
      ack_reg <= pg_ok && (host_req_i.wr || host_req_i.rd) && hit; // R1
      if (pg_ok && host_req_i.rd && hit) begin
        rdata_reg <= presence_cfg_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end
  assign host_rdata_o = rdata_reg;
  assign host_ack_o = ack_reg;
  assign slow_clock_absent_flag_o = presence_cfg_reg[`SCS_ABSENT_BIT]; // R5

  // ----------------------------------------
  // Internal 32 kHz divider
  // ----------------------------------------
  localparam int CW = $clog2(DIV_HALF + 1);
  logic [CW-1:0] div_cnt_reg; // Reference ticks counted
  logic int_clk_reg; // Derived slow clock

  // Toggle every DIV_HALF reference ticks; only live with main supply
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= '0;
      int_clk_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (!pg_ok) begin // R8
        div_cnt_reg <= '0;
      end else if (ref_tick_i) begin
        if (div_cnt_reg == CW'(DIV_HALF - 1)) begin
          div_cnt_reg <= '0;
          int_clk_reg <= ~int_clk_reg; // R7
        end else begin
          div_cnt_reg <= div_cnt_reg + CW'(1);
        end
      end
    end
  end
  assign internal_source_valid_o = pg_ok; // R8

  // ----------------------------------------
  // Glitch-free source switch
  // ----------------------------------------
  scs_mux_state_type state_reg; // Switch state
  logic sel_int_reg; // Source now used
  logic out_reg; // Selected clock
  logic want_int;
  logic cur_src;

  assign want_int = presence_cfg_reg[`SCS_ABSENT_BIT];
  assign cur_src = sel_int_reg ? int_clk_reg : ext_clk;

  // Wait for low on old source, hold low, then wait for low on new source
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SCS_RUN;
      sel_int_reg <= 1'b0;
      out_reg <= 1'b0;
    end else if (clk_en_i) begin
      unique case (state_reg)
        SCS_RUN: begin
          // Pass the current source
          out_reg <= cur_src; // R7
          if (want_int != sel_int_reg && !cur_src) begin
            state_reg <= SCS_GATE_OFF; // R10
            out_reg <= 1'b0;
          end
        end
        SCS_GATE_OFF: begin
          // Output held low while switching
          out_reg <= 1'b0;
          sel_int_reg <= want_int;
          state_reg <= SCS_SWAP;
        end
        SCS_SWAP: begin
          // Resume only at a low phase of the new source
          out_reg <= 1'b0;
          if (!cur_src) begin
            state_reg <= SCS_RUN; // R10
          end
        end
      endcase
    end
  end
  assign slow_clock_o = out_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_swap_start;
    state_reg == SCS_RUN && want_int != sel_int_reg && !cur_src && clk_en_i;
  endsequence

  a_ignore_host_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
    !pg_ok |=> !host_ack_o)
    else $error("host access acknowledged with supply low");
  a_cfg_hold_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
    (!pg_ok || !clk_en_i) |=> $stable(presence_cfg_reg))
    else $error("config changed with supply low");
  a_wake_pass: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R2
    clk_en_i ##1 clk_en_i |=> wake_pins_o == $past(wake_s1_reg))
    else $error("wake pins not passed");
  // Timeout enable follows the supply pin through exactly two enabled stages
  a_ir_timeout_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R3
    $past(rst_n_i) && $past(rst_n_i, 2) && $past(clk_en_i) && $past(clk_en_i, 2)
      |-> ir_timeout_enable_o == $past(supply_good_indicator_i, 2))
    else $error("ir timeout not tied to supply good");
  // Bit 0 of a read of the config byte is the absent flag
  a_flag_bit: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
    clk_en_i && pg_ok && host_req_i.rd && hit |=> host_rdata_o[`SCS_ABSENT_BIT] == $past(slow_clock_absent_flag_o))
    else $error("flag not at bit 0");
  a_cfg_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R9
    clk_en_i && pg_ok && host_req_i.wr && hit |=> presence_cfg_reg == $past(host_req_i.wdata))
    else $error("config write lost");
  a_div_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R8
    clk_en_i && !pg_ok |=> div_cnt_reg == '0)
    else $error("divider ran without supply");
  a_swap_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    s_swap_start |=> !slow_clock_o [*2])
    else $error("glitch during source switch");
  a_src_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
    state_reg == SCS_RUN && clk_en_i && want_int == sel_int_reg |=> slow_clock_o == $past(cur_src))
    else $error("slow clock not following selected source");
endmodule
`default_nettype wire

// [bench/scs_osc_model.sv]
`default_nettype none
// External slow oscillator; the pin is grounded while it is absent
module scs_osc_model #(
  parameter int HALF_NS = 200
) (
  // Run control and clock pin
  input wire logic run_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin_o = 1'b0;
    forever begin
      #(HALF_NS);
      pin_o = run_i ? ~pin_o : 1'b0;
    end
  end
endmodule
`default_nettype wire

// [bench/scs_slow_clock_tb.sv]
`default_nettype none
module scs_slow_clock_tb;
  import scs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, sg = 1'b0, run = 1'b0, tick = 1'b0, en = 1'b1, pin;
  scs_host_req_type req = '0;
  scs_wake_pins_type wi = '0, wo;
  logic [7:0] rdata, rd_v;
  logic ack, sclk, absent, ir_en, int_ok, got_ack;
  int bad_count = 0, checks = 0, cyc = 0, tcnt = 0, hr = 0, min_hi = 1000;
  always #2.5 mclk_i = ~mclk_i;
  scs_osc_model #(.HALF_NS(200)) osc (.run_i(run), .pin_o(pin));
  scs_slow_clock #(.DIV_HALF(2)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(en),
    .supply_good_indicator_i(sg), .host_req_i(req), .host_rdata_o(rdata), .host_ack_o(ack),
    .slow_clock_input_pin_i(pin), .ref_tick_i(tick), .wake_pins_i(wi), .wake_pins_o(wo),
    .slow_clock_o(sclk), .slow_clock_absent_flag_o(absent), .ir_timeout_enable_o(ir_en),
    .internal_source_valid_o(int_ok));
  // Reference tick every 14 cycles
  always @(negedge mclk_i) begin
    tcnt <= (tcnt == 13) ? 0 : tcnt + 1;
    tick <= (tcnt == 13);
  end
  // Timeout and shortest high phase of the slow clock, sampled where it is settled
  always @(negedge mclk_i) begin
    cyc <= cyc + 1;
    hr <= (sclk === 1'b1) ? hr + 1 : 0;
    if (sclk !== 1'b1 && hr != 0 && hr < min_hi)
      min_hi <= hr;
    if (cyc == 10000) begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One host access held for one edge; ack captured in the next two cycles
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    got_ack = 1'b0;
    rd_v = 8'h00;
    repeat (2) begin
      @(negedge mclk_i);
      req <= '0;
      if (ack === 1'b1) begin
        got_ack = 1'b1;
        rd_v = rdata;
      end
    end
  endtask
  // Rising edges of the slow clock in 800 cycles after settling
  task automatic edges(input string what, input int lo, input int up);
    int n;
    logic p;
    n = 0;
    repeat (150) @(negedge mclk_i);
    p = sclk;
    repeat (800) begin
      @(negedge mclk_i);
      if (sclk === 1'b1 && p === 1'b0)
        n++;
      p = sclk;
    end
    chk(what, 8'h01, {7'h0, n >= lo && n <= up});
  endtask
  task automatic end_of_test();
    $display("Counts: checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_n_i <= 1'b1;
    wi <= 6'h2d;
    repeat (4) @(negedge mclk_i);
    chk("wake pins", 8'h2d, {2'b0, wo});
    chk("ir timeout", 8'h00, {7'h0, ir_en});
    chk("int source off", 8'h00, {7'h0, int_ok});
    acc(1'b1, 8'hf0, 8'h01);
    chk("ack low supply", 8'h00, {7'h0, got_ack});
    $display("Test low supply done");
    sg <= 1'b1;
    repeat (4) @(negedge mclk_i);
    chk("ir timeout", 8'h01, {7'h0, ir_en});
    chk("int source on", 8'h01, {7'h0, int_ok});
    acc(1'b0, 8'hf0, 8'h00);
    chk("reset value", 8'h00, rd_v);
    chk("ack", 8'h01, {7'h0, got_ack});
    acc(1'b0, 8'he0, 8'h00);
    chk("unmapped ack", 8'h00, {7'h0, got_ack});
    // Clock enable low freezes the block, so this write is lost
    en <= 1'b0;
    acc(1'b1, 8'hf0, 8'h01);
    chk("frozen ack", 8'h00, {7'h0, got_ack});
    chk("frozen flag", 8'h00, {7'h0, absent});
    en <= 1'b1;
    run <= 1'b1;
    edges("ext edges", 9, 11);
    $display("Test external source done");
    acc(1'b1, 8'hf0, 8'ha5);
    acc(1'b0, 8'hf0, 8'h00);
    chk("readback", 8'ha5, rd_v);
    chk("flag", 8'h01, {7'h0, absent});
    run <= 1'b0;
    edges("int edges", 13, 15);
    // Oscillator back on before software clears the flag again
    run <= 1'b1;
    acc(1'b1, 8'hf0, 8'h00);
    edges("back to external", 9, 11);
    chk("min high", 8'h01, {7'h0, min_hi >= 12});
    $display("Test source switch done");
    acc(1'b1, 8'hf0, 8'h01);
    rst_n_i <= 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(negedge mclk_i);
    acc(1'b0, 8'hf0, 8'h00);
    chk("after reset", 8'h00, rd_v);
    $display("Test trickle reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
